// ===== srwcfg_top.v
// Fail-safe reaction and watchdog configuration register bank
`include "srwcfg_defines.vh"

// Summary of operation
// - Bit 13 includes monitor four in self-test
// - Bits 11:10 hold I/O overvoltage reaction
// - Bits 9:8 hold I/O undervoltage reaction
// - Monitors four and three fields, bits 23:16
// - Monitors two and one fields, bits 15:8
// - Bits 23:22 error ceiling, reset 01
// - Bits 20:19 refresh ceiling, reset 00
// - Bits 17:16 watchdog reaction, reset 10
// - Bits 14:12 read refresh counter 0-7
// - Bits 11:8 read error counter 0-8
module srwcfg_top (
    input wire sys_clk,
    input wire sys_rst,
    input wire wr_en,
    input wire rd_en,
    input wire [1:0] reg_addr,
    input wire [23:0] wr_data,
    input wire [2:0] wdog_refresh_count_in,
    input wire [3:0] wdog_error_count_in,
    output wire [23:0] rd_data,
    output wire rd_valid,
    output wire mon4_selftest_incl,
    output wire [1:0] io_supply_over_reaction,
    output wire [1:0] io_supply_under_reaction,
    output wire [1:0] mon4_over_reaction,
    output wire [1:0] mon4_under_reaction,
    output wire [1:0] mon3_over_reaction,
    output wire [1:0] mon3_under_reaction,
    output wire [1:0] mon2_over_reaction,
    output wire [1:0] mon2_under_reaction,
    output wire [1:0] mon1_over_reaction,
    output wire [1:0] mon1_under_reaction,
    output wire [1:0] wdog_error_ceiling,
    output wire [1:0] wdog_refresh_ceiling,
    output wire [1:0] wdog_failure_reaction
);

    // ****************************************
    // Storage
    // ****************************************
    // Configuration fields, all cleared to their defaults by reset
    // First reaction register fields
    reg mon4_incl_ff;
    reg [1:0] io_over_ff;
    reg [1:0] io_under_ff;
    // Second reaction register, one nibble per monitor, monitor one lowest
    wire [15:0] mon_react;
    // Watchdog setup fields
    reg [1:0] err_ceil_ff;
    reg [1:0] rfr_ceil_ff;
    reg [1:0] wd_react_ff;
    // Counter mirrors and the saturated error count
    reg [2:0] rfr_cnt_ff;
    reg [3:0] err_cnt_ff;
    reg [3:0] nxt_err_cnt;
    // Read images, reserved positions held at zero
    reg [23:0] reaction_one_img;
    reg [23:0] reaction_two_img;
    reg [23:0] wdog_setup_img;

    // ****************************************
    // Write decode
    // ****************************************
    // A write to the unmapped select raises no strobe and is dropped
    wire wr_one;
    wire wr_two;
    wire wr_wdog;

    // Write strobes per register
    assign wr_one = wr_en && (reg_addr == `SRWCFG_ADDR_REACTION_ONE);
    assign wr_two = wr_en && (reg_addr == `SRWCFG_ADDR_REACTION_TWO);
    assign wr_wdog = wr_en && (reg_addr == `SRWCFG_ADDR_WDOG_SETUP);

    // ****************************************
    // First reaction register
    // ****************************************
    // Reserved bit 12 and bits outside these fields are dropped on write
    // Self-test inclusion bit
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            mon4_incl_ff <= `SRWCFG_MON4_INCL_RST;
            io_over_ff <= `SRWCFG_IO_OVER_RST;
            io_under_ff <= `SRWCFG_IO_UNDER_RST;
        end else if (wr_one) begin
            mon4_incl_ff <= wr_data[`SRWCFG_MON4_INCL_BIT];
            io_over_ff <= wr_data[`SRWCFG_IO_OVER_HI:`SRWCFG_IO_OVER_LO];
            io_under_ff <= wr_data[`SRWCFG_IO_UNDER_HI:`SRWCFG_IO_UNDER_LO];
        end
    end

    // ****************************************
    // Second reaction register, one slice per monitor
    // ****************************************
    genvar mon_idx;
    generate
        for (mon_idx = 0; mon_idx < 4; mon_idx = mon_idx + 1) begin : g_mon
            reg [3:0] slice_ff;

            // Over field on top, under below
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    slice_ff[3:2] <= `SRWCFG_MON_OVER_RST;
                    slice_ff[1:0] <= `SRWCFG_MON_UNDER_RST;
                end else if (wr_two) begin
                    slice_ff <=
                        wr_data[`SRWCFG_MON_FIELD_LSB+mon_idx*4+3:
                                `SRWCFG_MON_FIELD_LSB+mon_idx*4];
                end
            end

            // Each slice drives only its own nibble, so one driver per bit
            assign mon_react[mon_idx*4+3:mon_idx*4] = slice_ff;
        end
    endgenerate

    // ****************************************
    // Watchdog setup register
    // ****************************************
    // Counter fields 14:8 take no write data, writes there are dropped
    // Error ceiling field
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            err_ceil_ff <= `SRWCFG_ERR_CEIL_RST;
            rfr_ceil_ff <= `SRWCFG_RFR_CEIL_RST;
            wd_react_ff <= `SRWCFG_WD_REACT_RST;
        end else if (wr_wdog) begin
            err_ceil_ff <= wr_data[`SRWCFG_ERR_CEIL_HI:`SRWCFG_ERR_CEIL_LO];
            rfr_ceil_ff <= wr_data[`SRWCFG_RFR_CEIL_HI:`SRWCFG_RFR_CEIL_LO];
            wd_react_ff <= wr_data[`SRWCFG_WD_REACT_HI:`SRWCFG_WD_REACT_LO];
        end
    end

    // ****************************************
    // Counter mirrors
    // ****************************************
    // Counters follow the watchdog logic one cycle late
    // Error counter never shows above eight
    always @* begin
        nxt_err_cnt = wdog_error_count_in;
        if (wdog_error_count_in > `SRWCFG_ERR_CNT_MAX) begin
            nxt_err_cnt = `SRWCFG_ERR_CNT_MAX;
        end
    end

    // Counter mirrors, cleared at reset, not writable
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rfr_cnt_ff <= `SRWCFG_RFR_CNT_RST;
            err_cnt_ff <= `SRWCFG_ERR_CNT_RST;
        end else begin
            rfr_cnt_ff <= wdog_refresh_count_in;
            err_cnt_ff <= nxt_err_cnt;
        end
    end

    // ****************************************
    // Read images
    // ****************************************
    // A read alongside a write sees the old contents
    // Reserved and absent positions read zero
    always @* begin
        reaction_one_img = 24'h000000;
        reaction_one_img[`SRWCFG_MON4_INCL_BIT] = mon4_incl_ff;
        reaction_one_img[`SRWCFG_IO_OVER_HI:`SRWCFG_IO_OVER_LO] = io_over_ff;
        reaction_one_img[`SRWCFG_IO_UNDER_HI:`SRWCFG_IO_UNDER_LO] = io_under_ff;
        reaction_two_img = 24'h000000;
        reaction_two_img[`SRWCFG_MON_FIELD_LSB+15:`SRWCFG_MON_FIELD_LSB] = mon_react;
        wdog_setup_img = 24'h000000;
        wdog_setup_img[`SRWCFG_ERR_CEIL_HI:`SRWCFG_ERR_CEIL_LO] = err_ceil_ff;
        wdog_setup_img[`SRWCFG_RFR_CEIL_HI:`SRWCFG_RFR_CEIL_LO] = rfr_ceil_ff;
        wdog_setup_img[`SRWCFG_WD_REACT_HI:`SRWCFG_WD_REACT_LO] = wd_react_ff;
        wdog_setup_img[`SRWCFG_RFR_CNT_HI:`SRWCFG_RFR_CNT_LO] = rfr_cnt_ff;
        wdog_setup_img[`SRWCFG_ERR_CNT_HI:`SRWCFG_ERR_CNT_LO] = err_cnt_ff;
    end

    // Read data come from a register, so a read answers one cycle later
    // Registered read return
    srwcfg_read_reg u_read_reg (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rd_en(rd_en),
        .rd_addr(reg_addr),
        .reaction_one_img(reaction_one_img),
        .reaction_two_img(reaction_two_img),
        .wdog_setup_img(wdog_setup_img),
        .rd_data_ff(rd_data),
        .rd_valid_ff(rd_valid)
    );

    // ****************************************
    // Configuration outputs, straight from storage
    // ****************************************
    // Self-test inclusion output
    assign mon4_selftest_incl = mon4_incl_ff;

    assign io_supply_over_reaction = io_over_ff;
    assign io_supply_under_reaction = io_under_ff;

    assign mon4_over_reaction = mon_react[15:14];
    assign mon4_under_reaction = mon_react[13:12];
    assign mon3_over_reaction = mon_react[11:10];
    assign mon3_under_reaction = mon_react[9:8];

    assign mon2_over_reaction = mon_react[7:6];
    assign mon2_under_reaction = mon_react[5:4];
    assign mon1_over_reaction = mon_react[3:2];
    assign mon1_under_reaction = mon_react[1:0];

    assign wdog_error_ceiling = err_ceil_ff;
    assign wdog_refresh_ceiling = rfr_ceil_ff;
    assign wdog_failure_reaction = wd_react_ff;

endmodule // srwcfg_top

// ===== srwcfg_defines.vh
// Constants for the safety reaction and watchdog configuration register bank
`ifndef SRWCFG_DEFINES_VH
`define SRWCFG_DEFINES_VH

// ****************************************
// Register selection codes
// ****************************************
`define SRWCFG_ADDR_REACTION_ONE 2'h0
`define SRWCFG_ADDR_REACTION_TWO 2'h1
`define SRWCFG_ADDR_WDOG_SETUP 2'h2

// ****************************************
// First reaction register fields
// ****************************************
`define SRWCFG_MON4_INCL_BIT 13
`define SRWCFG_IO_OVER_HI 11
`define SRWCFG_IO_OVER_LO 10
`define SRWCFG_IO_UNDER_HI 9
`define SRWCFG_IO_UNDER_LO 8
`define SRWCFG_MON4_INCL_RST 1'h0
`define SRWCFG_IO_OVER_RST 2'h3
`define SRWCFG_IO_UNDER_RST 2'h1

// ****************************************
// Second reaction register fields
// ****************************************
`define SRWCFG_MON_FIELD_LSB 8
`define SRWCFG_MON_OVER_RST 2'h3
`define SRWCFG_MON_UNDER_RST 2'h1

// ****************************************
// Watchdog setup register fields
// ****************************************
`define SRWCFG_ERR_CEIL_HI 23
`define SRWCFG_ERR_CEIL_LO 22
`define SRWCFG_RFR_CEIL_HI 20
`define SRWCFG_RFR_CEIL_LO 19
`define SRWCFG_WD_REACT_HI 17
`define SRWCFG_WD_REACT_LO 16
`define SRWCFG_RFR_CNT_HI 14
`define SRWCFG_RFR_CNT_LO 12
`define SRWCFG_ERR_CNT_HI 11
`define SRWCFG_ERR_CNT_LO 8
`define SRWCFG_ERR_CEIL_RST 2'h1
`define SRWCFG_RFR_CEIL_RST 2'h0
`define SRWCFG_WD_REACT_RST 2'h2
`define SRWCFG_RFR_CNT_RST 3'h0
`define SRWCFG_ERR_CNT_RST 4'h0
`define SRWCFG_ERR_CNT_MAX 4'h8

`endif

// ===== srwcfg_read_reg.v
// Registered read data return for the register bank
`include "srwcfg_defines.vh"

module srwcfg_read_reg (
    input wire sys_clk,
    input wire sys_rst,
    input wire rd_en,
    input wire [1:0] rd_addr,
    input wire [23:0] reaction_one_img,
    input wire [23:0] reaction_two_img,
    input wire [23:0] wdog_setup_img,
    output reg [23:0] rd_data_ff,
    output reg rd_valid_ff
);

    reg [23:0] nxt_rd_data;

    // Select image of addressed register, unmapped reads zero
    always @* begin
        nxt_rd_data = 24'h000000;
        case (rd_addr)
            `SRWCFG_ADDR_REACTION_ONE: nxt_rd_data = reaction_one_img;
            `SRWCFG_ADDR_REACTION_TWO: nxt_rd_data = reaction_two_img;
            `SRWCFG_ADDR_WDOG_SETUP: nxt_rd_data = wdog_setup_img;
            default: nxt_rd_data = 24'h000000;
        endcase
    end

    // Capture read data, hold it until the next read
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_ff <= 24'h000000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

endmodule // srwcfg_read_reg

// ===== srwcfg_chk_sva.sv
// Concurrent checks on the reaction and watchdog configuration register bank
module srwcfg_chk (
    input logic sys_clk,
    input logic sys_rst,
    input logic wr_en,
    input logic rd_en,
    input logic [1:0] reg_addr,
    input logic [23:0] wr_data,
    input logic [2:0] wdog_refresh_count_in,
    input logic [3:0] wdog_error_count_in,
    input logic [23:0] rd_data,
    input logic rd_valid,
    input logic mon4_selftest_incl,
    input logic [1:0] io_supply_over_reaction,
    input logic [1:0] io_supply_under_reaction,
    input logic [1:0] mon4_over_reaction,
    input logic [1:0] mon4_under_reaction,
    input logic [1:0] mon3_over_reaction,
    input logic [1:0] mon3_under_reaction,
    input logic [1:0] mon2_over_reaction,
    input logic [1:0] mon2_under_reaction,
    input logic [1:0] mon1_over_reaction,
    input logic [1:0] mon1_under_reaction,
    input logic [1:0] wdog_error_ceiling,
    input logic [1:0] wdog_refresh_ceiling,
    input logic [1:0] wdog_failure_reaction
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [23:0] wd_q;
    logic [2:0] rc_q, rc_q2;
    logic [3:0] ec_q, ec_q2;
    wire w0 = wr_en && reg_addr == 2'h0;
    wire w1 = wr_en && reg_addr == 2'h1;
    wire w2 = wr_en && reg_addr == 2'h2;
    wire r2 = rd_en && reg_addr == 2'h2;
    // Delayed copies of write data and counter inputs
    always @(posedge sys_clk) begin
        wd_q <= wr_data;
        rc_q <= wdog_refresh_count_in;
        rc_q2 <= rc_q;
        ec_q <= wdog_error_count_in;
        ec_q2 <= ec_q;
    end
    a_incl_capture: assert property (w0 |=> mon4_selftest_incl == wd_q[13])
        else $error("selftest include bit not captured");
    a_io_over_capture: assert property (w0 |=> io_supply_over_reaction == wd_q[11:10])
        else $error("io over reaction not captured");
    a_io_under_capture: assert property (w0 |=> io_supply_under_reaction == wd_q[9:8])
        else $error("io under reaction not captured");
    a_mon43_capture: assert property (w1 |=>
        {mon4_over_reaction, mon4_under_reaction, mon3_over_reaction, mon3_under_reaction}
        == wd_q[23:16])
        else $error("monitor four or three field wrong");
    a_mon21_capture: assert property (w1 |=>
        {mon2_over_reaction, mon2_under_reaction, mon1_over_reaction, mon1_under_reaction}
        == wd_q[15:8])
        else $error("monitor two or one field wrong");
    a_wdog_cfg_capture: assert property (w2 |=> {wdog_error_ceiling,
        wdog_refresh_ceiling, wdog_failure_reaction} == {wd_q[23:22], wd_q[20:19], wd_q[17:16]})
        else $error("watchdog setup field wrong");
    a_rfr_cnt_read: assert property (r2 && !$past(sys_rst) |=> rd_data[14:12] == rc_q2)
        else $error("refresh count read wrong");
    a_err_cnt_read: assert property (r2 && !$past(sys_rst) |=>
        rd_data[11:8] == (ec_q2 > 4'h8 ? 4'h8 : ec_q2))
        else $error("error count read wrong");
    a_rsv_read_zero: assert property (r2 |=>
        {rd_data[21], rd_data[18], rd_data[15], rd_data[7:0]} == 11'h000)
        else $error("reserved bits not zero");
    a_reset_values: assert property ($fell(sys_rst) |->
        {mon4_selftest_incl, io_supply_over_reaction, io_supply_under_reaction} == 5'h0D &&
        {mon4_over_reaction, mon4_under_reaction, mon3_over_reaction, mon3_under_reaction,
        mon2_over_reaction, mon2_under_reaction, mon1_over_reaction, mon1_under_reaction}
        == 16'hDDDD &&
        {wdog_error_ceiling, wdog_refresh_ceiling, wdog_failure_reaction} == 6'h12 &&
        !rd_valid && rd_data == 24'h000000)
        else $error("reset values wrong");
    a_rd_valid_pulse: assert property (1'h1 |=> rd_valid == $past(rd_en))
        else $error("read valid not one cycle after read strobe");
endmodule // srwcfg_chk

// ===== testbench.sv
// Self-checking bench for the reaction and watchdog configuration bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, sys_rst, wr_en, rd_en, rd_valid;
    logic [1:0] reg_addr;
    logic [23:0] wr_data, rd_data;
    logic [2:0] rc;
    logic [3:0] ec;
    int err_count = 0;
    int samples_checked = 0;
    srwcfg_top i_srwcfg_top (.sys_clk, .sys_rst, .wr_en, .rd_en, .reg_addr, .wr_data,
        .wdog_refresh_count_in(rc), .wdog_error_count_in(ec), .rd_data, .rd_valid,
        .mon4_selftest_incl(), .io_supply_over_reaction(), .io_supply_under_reaction(),
        .mon4_over_reaction(), .mon4_under_reaction(), .mon3_over_reaction(),
        .mon3_under_reaction(), .mon2_over_reaction(), .mon2_under_reaction(),
        .mon1_over_reaction(), .mon1_under_reaction(), .wdog_error_ceiling(),
        .wdog_refresh_ceiling(), .wdog_failure_reaction());
    // Bus write, one strobe cycle
    task automatic wr(input logic [1:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        wr_en <= 1'h1;
        reg_addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'h0;
    endtask
    // Bus read, judged with its valid flag
    task automatic rd(input logic [1:0] a, input logic [23:0] e);
        @(posedge sys_clk);
        rd_en <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'h0;
        #1;
        samples_checked++;
        if ({rd_valid, rd_data} !== {1'h1, e}) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, {rd_valid, rd_data}, {1'h1, e});
        end
    endtask
    task automatic t_reset;
        rd(2'h0, 24'h000D00);
        rd(2'h1, 24'hDDDD00);
        rd(2'h2, 24'h420000);
        $display("reset values done");
    endtask
    task automatic t_fields;
        wr(2'h0, 24'hFFFFFF);
        rd(2'h0, 24'h002F00);
        wr(2'h0, 24'h001600);
        rd(2'h0, 24'h000600);
        wr(2'h1, 24'h1B27FF);
        rd(2'h1, 24'h1B2700);
        wr(2'h1, 24'hE4D800);
        rd(2'h1, 24'hE4D800);
        $display("reaction fields done");
    endtask
    task automatic t_wdog;
        @(posedge sys_clk);
        rc <= 3'h7;
        ec <= 4'h9;
        wr(2'h2, 24'hFFFFFF);
        rd(2'h2, 24'hDB7800);
        @(posedge sys_clk);
        rc <= 3'h2;
        ec <= 4'h5;
        wr(2'h2, 24'h240000);
        rd(2'h2, 24'h002500);
        $display("watchdog setup done");
    endtask
    // Reset in mid-run must restore every written field
    task automatic t_mid_reset;
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        rc <= 3'h0;
        ec <= 4'h0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        t_reset;
        $display("mid-run reset done");
    endtask
    task automatic t_unmapped;
        wr(2'h3, 24'hFFFFFF);
        rd(2'h3, 24'h000000);
        rd(2'h2, 24'h002500);
        $display("unmapped access done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Main sequence after a ten cycle reset
    initial begin
        sys_rst = 1'h1;
        wr_en = 1'h0;
        rd_en = 1'h0;
        reg_addr = 2'h0;
        wr_data = 24'h000000;
        rc = 3'h0;
        ec = 4'h0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        t_reset;
        t_fields;
        t_wdog;
        t_unmapped;
        t_mid_reset;
        wrap_up;
    end
    // Watchdog against a hang
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_count++;
        wrap_up;
    end
endmodule // testbench
bind srwcfg_top srwcfg_chk i_srwcfg_chk (.sys_clk, .sys_rst, .wr_en, .rd_en, .reg_addr,
    .wr_data, .wdog_refresh_count_in, .wdog_error_count_in, .rd_data, .rd_valid,
    .mon4_selftest_incl, .io_supply_over_reaction, .io_supply_under_reaction,
    .mon4_over_reaction, .mon4_under_reaction, .mon3_over_reaction, .mon3_under_reaction,
    .mon2_over_reaction, .mon2_under_reaction, .mon1_over_reaction, .mon1_under_reaction,
    .wdog_error_ceiling, .wdog_refresh_ceiling, .wdog_failure_reaction);
